/* File: rtcpc_defines.svh */
// Constants for the RTC pin control block
`ifndef RTCPC_DEFINES_SVH
`define RTCPC_DEFINES_SVH
`define RTCPC_WIN_LO        16'h1900
`define RTCPC_WIN_HI        16'h197f
`define RTCPC_CLKOUT_EN_RST 1'b0
`define RTCPC_WAKE_OUT_RST  1'b0
`define RTCPC_XTAL_HZ       32768
`define RTCPC_SYS_HZ        10000000
`define RTCPC_XTAL_DIV      ((`RTCPC_SYS_HZ / (2 * `RTCPC_XTAL_HZ)) < 1 ? 1 : \
	(`RTCPC_SYS_HZ / (2 * `RTCPC_XTAL_HZ)))
`endif

/* File: rtcpc_pkg.sv */
// Types for the RTC pin control block
package rtcpc_pkg;
	typedef enum logic [1:0] {
		RTCPC_IDLE  = 2'b00,
		RTCPC_WAKE  = 2'b01,
		RTCPC_ALARM = 2'b10
	} rtcpc_state_t;
endpackage : rtcpc_pkg

/* File: rtcpc_top.sv */
// RTC pin control: clock output gating, wake pin, register window blocking
// Functional notes
// - Drive the RTC clock output only while the enable bit is set, else Hi-Z.
// - After reset the RTC clock output stays Hi-Z until software enables it.
// - Wake pin as input: an assertion wakes the core from idle.
// - At RTC supply power-up the wake pin is an input.
// - Wake pin as output: open-drain, pulled low on alarm, else released.
// - Oscillator off: RTC window 1900h to 197Fh is inaccessible.
// - RTC time is kept from the 32.768 kHz crystal clock.
`timescale 1ns/1ps
`include "rtcpc_defines.svh"
module rtcpc_top
	import rtcpc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        clock_output_enable_bit,
	input  wire logic        wake_as_output,
	input  wire logic        rtc_alarm,
	input  wire logic        wake_pin_in,
	input  wire logic        osc_enable,
	input  wire logic        core_idle,
	input  wire logic        bus_req,
	input  wire logic        bus_we,
	input  wire logic [15:0] bus_addr,
	input  wire logic [15:0] rtc_rdata,
	output logic             rtc_clock_output_pin_o,
	output logic             rtc_clock_output_pin_oe,
	output logic             wake_pin_o,
	output logic             wake_pin_oe,
	output logic             core_wake,
	output logic             rtc_sel,
	output logic             rtc_we,
	output logic             bus_ack,
	output logic [15:0]      bus_rdata
);

	function automatic logic in_window(input logic [15:0] a);
		in_window = (a >= `RTCPC_WIN_LO) && (a <= `RTCPC_WIN_HI);
	endfunction : in_window

	localparam logic [8:0] DIV_LAST = 9'(`RTCPC_XTAL_DIV - 1);

	logic [8:0]   div_q;
	logic         xtal_q;
	rtcpc_state_t st_q;
	rtcpc_state_t st_d;
	logic         clk_pin_q;
	logic         clk_oe_q;
	logic         wake_o_q;
	logic         wake_oe_q;
	logic         core_wake_q;
	logic         sel_q;
	logic         we_q;
	logic         ack_q;
	logic [15:0]  rdata_q;

	wire hit      = bus_req && in_window(bus_addr);
	wire win_open = hit && osc_enable;
	wire wake_in  = !wake_as_output && !wake_pin_in;
	wire div_wrap = (div_q == DIV_LAST);
	// Next values of the pin, core wake, bus and divider flops
	wire        clk_pin_d   = clock_output_enable_bit & xtal_q;
	wire        clk_oe_d    = clock_output_enable_bit;
	wire        wake_oe_d   = (st_d == RTCPC_ALARM);
	wire        core_wake_d = (st_d == RTCPC_WAKE);
	wire        sel_d       = win_open;
	wire        we_d        = win_open && bus_we;
	wire        ack_d       = hit;
	wire [15:0] rdata_d     = (win_open && !bus_we) ? rtc_rdata : 16'h0000;
	wire [8:0]  div_d       = div_wrap ? 9'h000 : div_q + 9'h001;

	// Approximate crystal tick model on the system clock; the true crystal
	// sits outside this clock domain, so this only paces the output pin.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			div_q  <= 9'h000;
			xtal_q <= 1'b0;
		end else if (clk_en) begin
			div_q  <= div_d;
			if (div_wrap)
				xtal_q <= !xtal_q;
		end
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			RTCPC_IDLE:  st_d = wake_as_output ? (rtc_alarm ? RTCPC_ALARM : RTCPC_IDLE)
				: (wake_in && core_idle ? RTCPC_WAKE : RTCPC_IDLE);
			RTCPC_WAKE:  st_d = (wake_as_output && rtc_alarm) ? RTCPC_ALARM : RTCPC_IDLE;
			RTCPC_ALARM: st_d = (wake_as_output && rtc_alarm) ? RTCPC_ALARM : RTCPC_IDLE;
			default:     st_d = RTCPC_IDLE;
		endcase
	end

	// Enable bit gates drive and level together, so a disabled pin shows no edges
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clk_pin_q <= 1'b0;
			clk_oe_q  <= `RTCPC_CLKOUT_EN_RST;
		end else if (clk_en) begin
			clk_pin_q <= clk_pin_d;
			clk_oe_q  <= clk_oe_d;
		end
	end

	AST_CLKOUT_LOW_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !clock_output_enable_bit |=> !rtc_clock_output_pin_o)
		else $error("clock output level moves while disabled");
	AST_XTAL_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !div_wrap |=> xtal_q == $past(xtal_q))
		else $error("crystal pacing toggled early");
	AST_DIV_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		div_q <= DIV_LAST)
		else $error("crystal pacing divider out of range");
	AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!clk_en |=> $stable(div_q) && $stable(xtal_q) && $stable(st_q)
			&& $stable(rtc_clock_output_pin_oe) && $stable(wake_pin_oe) && $stable(bus_ack))
		else $error("state moved while clock enable was low");

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q        <= RTCPC_IDLE;
			wake_o_q    <= 1'b0;
			wake_oe_q   <= `RTCPC_WAKE_OUT_RST;
			core_wake_q <= 1'b0;
		end else if (clk_en) begin
			st_q        <= st_d;
			wake_o_q    <= 1'b0;
			wake_oe_q   <= wake_oe_d;
			core_wake_q <= core_wake_d;
		end
	end

	AST_WAKE_ALARM_PULL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && wake_as_output && rtc_alarm |=> wake_pin_oe)
		else $error("wake pin not pulled on alarm");
	AST_WAKE_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !(wake_as_output && rtc_alarm) |=> !wake_pin_oe)
		else $error("wake pin not released");
	AST_WAKE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && core_wake |=> !core_wake)
		else $error("core wake longer than one cycle");
	AST_WAKE_REFUSED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && wake_as_output |=> !core_wake)
		else $error("core woken while wake pin is an output");
	AST_WAKE_BUSY_CORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !core_idle |=> !core_wake)
		else $error("core woken while not idle");
	AST_STATE_LEGAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		st_q inside {RTCPC_IDLE, RTCPC_WAKE, RTCPC_ALARM})
		else $error("wake state left its legal codes");

	// Every window access is answered, even a blocked one,
	// so the processor never stalls on a stopped oscillator
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_q   <= 1'b0;
			we_q    <= 1'b0;
			ack_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else if (clk_en) begin
			sel_q   <= sel_d;
			we_q    <= we_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	AST_WINDOW_OPEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && win_open |=> rtc_sel && bus_ack && rtc_we == $past(bus_we))
		else $error("open window access not passed on");
	AST_OPEN_READ_DATA: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && win_open && !bus_we |=> bus_rdata == $past(rtc_rdata))
		else $error("window read data not returned");
	AST_OUTSIDE_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !hit |=> !bus_ack && !rtc_sel && !rtc_we)
		else $error("access outside window answered");
	AST_WRITE_RDATA_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && bus_we |=> bus_rdata == 16'h0000)
		else $error("write returned read data");
	AST_BLOCK_WR_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && hit && !osc_enable && bus_we |=> bus_ack && !rtc_we)
		else $error("blocked write not answered or not dropped");

	assign rtc_clock_output_pin_o  = clk_pin_q;
	assign rtc_clock_output_pin_oe = clk_oe_q;
	assign wake_pin_o              = wake_o_q;
	assign wake_pin_oe             = wake_oe_q;
	assign core_wake               = core_wake_q;
	assign rtc_sel                 = sel_q;
	assign rtc_we                  = we_q;
	assign bus_ack                 = ack_q;
	assign bus_rdata               = rdata_q;

	AST_CLKOUT_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && $past(rst_n) |=> rtc_clock_output_pin_oe == $past(clock_output_enable_bit))
		else $error("clock output enable does not follow enable bit");
	AST_CLKOUT_RESET: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> !rtc_clock_output_pin_oe)
		else $error("clock output driven right after reset");
	AST_WAKE_CORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && st_q == RTCPC_IDLE && !wake_as_output && !wake_pin_in && core_idle
		|=> core_wake)
		else $error("wake pin did not wake core");
	AST_WAKE_INPUT_DEFAULT: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> !wake_pin_oe)
		else $error("wake pin not an input after reset");
	AST_WAKE_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wake_pin_o == 1'b0)
		else $error("wake pin drives a high level");
	AST_WAKE_PULL_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(clk_en) && wake_pin_oe |-> $past(wake_as_output) && $past(rtc_alarm))
		else $error("wake pin pulled without alarm in output mode");
	AST_WINDOW_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && !osc_enable |=> !rtc_sel && !rtc_we)
		else $error("RTC window reached with oscillator off");
	AST_BLOCKED_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && hit && !osc_enable |=> bus_ack && bus_rdata == 16'h0000)
		else $error("blocked access not answered with zero");
	AST_XTAL_PACE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && div_wrap |=> div_q == 9'h000 && xtal_q != $past(xtal_q))
		else $error("crystal pacing divider wrong");

endmodule : rtcpc_top

/* File: rtcpc_wake_dev.sv */
// Model of the external device woken over the open-drain wake line
`timescale 1ns/1ps
module rtcpc_wake_dev (
	input  wire logic sys_clk,
	input  wire logic wake_pin_o,
	input  wire logic wake_pin_oe,
	input  wire logic ext_pull_n,
	output logic      wake_line,
	output logic      woken
);
	// Pull-up: the line only goes low while some party pulls it
	assign wake_line = ((wake_pin_oe && !wake_pin_o) || !ext_pull_n) ? 1'b0 : 1'b1;
	always_ff @(posedge sys_clk) begin
		woken <= wake_pin_oe && !wake_line;
	end
endmodule : rtcpc_wake_dev

/* File: rtcpc_top_tb.sv */
// Self-checking testbench for the RTC pin control block
`timescale 1ns/1ps
module rtcpc_top_tb;
	logic sys_clk = 0, rst_n = 0, clk_en = 1, clock_output_enable_bit = 0, wake_as_output = 0;
	logic rtc_alarm = 0, osc_enable = 1, core_idle = 1, bus_req = 0, bus_we = 0, pull_n = 1;
	logic [15:0] bus_addr = 16'h0000, rtc_rdata = 16'h5a3c, bus_rdata;
	logic rtc_clock_output_pin_o, rtc_clock_output_pin_oe, wake_pin_o, wake_pin_oe, core_wake;
	logic rtc_sel, rtc_we, bus_ack, wake_line, woken;
	int errors = 0, cmp_count = 0;
	always #50 sys_clk = ~sys_clk;
	rtcpc_top rtcpc_top_inst (.sys_clk, .rst_n, .clk_en, .clock_output_enable_bit,
		.wake_as_output, .rtc_alarm, .wake_pin_in(wake_line), .osc_enable, .core_idle,
		.bus_req, .bus_we, .bus_addr, .rtc_rdata, .rtc_clock_output_pin_o,
		.rtc_clock_output_pin_oe, .wake_pin_o, .wake_pin_oe, .core_wake, .rtc_sel, .rtc_we,
		.bus_ack, .bus_rdata);
	rtcpc_wake_dev rtcpc_wake_dev_inst (.sys_clk, .wake_pin_o, .wake_pin_oe,
		.ext_pull_n(pull_n), .wake_line, .woken);
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task t_clkout;
		int k;
		logic v;
		k = 0;
		clock_output_enable_bit = 1;
		cyc(2);
		chk("clk_oe_on", 1, rtc_clock_output_pin_oe);
		// Any 304-cycle span holds exactly two toggles of the divided crystal clock
		repeat (304) begin
			v = rtc_clock_output_pin_o;
			cyc(1);
			if (rtc_clock_output_pin_o !== v) k++;
		end
		chk("clk_toggles", 2, k);
		clock_output_enable_bit = 0;
		cyc(2);
		chk("clk_oe_off", 0, rtc_clock_output_pin_oe);
	endtask : t_clkout
	task t_wake;
		logic s;
		s = 0;
		pull_n = 0;
		core_idle = 0;
		repeat (4) begin cyc(1); s |= core_wake; end
		chk("wake_core_busy", 0, s);
		core_idle = 1;
		cyc(1);
		chk("core_wake", 1, core_wake);
		cyc(1);
		chk("core_wake_pulse", 0, core_wake);
		cyc(2);
		s = 0;
		wake_as_output = 1;
		repeat (4) begin cyc(1); s |= core_wake; end
		chk("wake_refused", 0, s);
		pull_n = 1;
		rtc_alarm = 1;
		cyc(3);
		chk("wake_pulled", 2, {wake_pin_oe, wake_line});
		chk("dev_woken", 1, woken);
		rtc_alarm = 0;
		cyc(2);
		chk("wake_released", 1, {wake_pin_oe, wake_line});
		chk("dev_released", 0, woken);
		wake_as_output = 0;
	endtask : t_wake
	task t_bus(input logic [15:0] a, input logic o, w, ea, es);
		logic k, s, we;
		logic [15:0] d;
		{k, s, we, d} = 0;
		{bus_addr, osc_enable, bus_we, bus_req} = {a, o, w, 1'b1};
		repeat (3) begin
			cyc(1);
			bus_req = 0;
			if (bus_ack === 1'b1) {k, s, we, d} = {1'b1, rtc_sel, rtc_we, bus_rdata};
		end
		chk("bus_ack", {ea, es, es & w}, {k, s, we});
		if (!w) chk("bus_rdata", es ? rtc_rdata : 16'h0000, d);
	endtask : t_bus
	task t_freeze;
		clk_en = 0;
		clock_output_enable_bit = 1;
		cyc(3);
		chk("frozen_oe", 0, rtc_clock_output_pin_oe);
		clk_en = 1;
		cyc(2);
		chk("thawed_oe", 1, rtc_clock_output_pin_oe);
		clock_output_enable_bit = 0;
		cyc(2);
		chk("thawed_oe_off", 0, rtc_clock_output_pin_oe);
	endtask : t_freeze
	task t_reset;
		clock_output_enable_bit = 1;
		wake_as_output = 1;
		rtc_alarm = 1;
		cyc(2);
		chk("pre_reset_oes", 3, {rtc_clock_output_pin_oe, wake_pin_oe});
		{rst_n, clock_output_enable_bit, wake_as_output, rtc_alarm} = 4'h0;
		cyc(2);
		chk("mid_reset_oes", 0, {rtc_clock_output_pin_oe, wake_pin_oe});
		rst_n = 1;
		cyc(2);
		chk("post_reset_oes", 0, {rtc_clock_output_pin_oe, wake_pin_oe});
	endtask : t_reset
	task conclude;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		cyc(6);
		chk("reset_oes", 0, {rtc_clock_output_pin_oe, wake_pin_oe});
		rst_n = 1;
		cyc(1);
		chk("after_reset", 0, {rtc_clock_output_pin_oe, wake_pin_oe, bus_ack});
		t_clkout;
		t_freeze;
		t_wake;
		t_bus(16'h1900, 1, 0, 1, 1);
		t_bus(16'h197f, 1, 1, 1, 1);
		t_bus(16'h197f, 0, 1, 1, 0);
		t_bus(16'h1900, 0, 0, 1, 0);
		t_bus(16'h1980, 1, 0, 0, 0);
		t_bus(16'h18ff, 1, 0, 0, 0);
		t_reset;
		conclude;
	end
endmodule : rtcpc_top_tb
